// ---- hw/ptss_pkg.sv ----
// constants, register map, step encodings and shared helpers of the
// peripheral trigger step sequencer; assumes one 200 MHz clock domain.
package ptss_pkg;

  // =====================================================================
  // bus and widths
  localparam int unsigned ADDR_W     = 5;
  localparam int unsigned DATA_W     = 16;
  localparam int unsigned STEP_W     = 8;
  localparam int unsigned QPTR_W     = 5;
  localparam int unsigned QUEUE_DEPTH = 8;
  localparam int unsigned TRIG_IN_W  = 16;
  localparam int unsigned TRIG_OUT_W = 32;
  localparam int unsigned IRQ_W      = 16;
  localparam int unsigned NUM_LIM    = 6;

  // =====================================================================
  // register offsets (word index on the plain port)
  localparam logic [ADDR_W-1:0] OFF_CTRL     = 5'h00;
  localparam logic [ADDR_W-1:0] OFF_STAT     = 5'h01;
  localparam logic [ADDR_W-1:0] OFF_ADJ      = 5'h02;
  localparam logic [ADDR_W-1:0] OFF_HOLD     = 5'h03;
  localparam logic [ADDR_W-1:0] OFF_LIM_BASE = 5'h04;
  localparam logic [ADDR_W-1:0] OFF_CNT0     = 5'h0A;
  localparam logic [ADDR_W-1:0] OFF_CNT1     = 5'h0B;
  localparam logic [ADDR_W-1:0] OFF_ADCSEL   = 5'h0C;
  localparam logic [ADDR_W-1:0] OFF_IRQ_STAT = 5'h0D;
  localparam logic [ADDR_W-1:0] OFF_IRQ_MASK = 5'h0E;
  localparam logic [ADDR_W-1:0] OFF_QUE_BASE = 5'h10;

  // =====================================================================
  // field positions
  localparam int unsigned CTRL_EN_BIT    = 0;
  localparam int unsigned CTRL_START_BIT = 1;
  localparam int unsigned STAT_WAIT_BIT  = 8;
  localparam int unsigned STAT_BUSY_BIT  = 9;
  localparam int unsigned ADCSEL_FIELD_W = 5;

  // =====================================================================
  // reset values
  localparam logic [DATA_W-1:0] RST_WORD = 16'h0000;
  localparam logic [STEP_W-1:0] RST_STEP = 8'h00;
  localparam logic [QPTR_W-1:0] RST_QPTR = 5'h00;

  // =====================================================================
  // opcode groups (opcode bits 3..1)
  localparam logic [2:0] GRP_CTRL_ADD = 3'h0;
  localparam logic [2:0] GRP_STROBE   = 3'h1;
  localparam logic [2:0] GRP_WAIT     = 3'h2;
  localparam logic [2:0] GRP_IRQ      = 3'h3;
  localparam logic [2:0] GRP_TRIG     = 3'h4;
  localparam logic [2:0] GRP_JUMP     = 3'h5;
  localparam logic [2:0] GRP_JMPC0    = 3'h6;
  localparam logic [2:0] GRP_JMPC1    = 3'h7;

  // control step option that loads the literal word into adc select
  localparam logic [3:0] CTRL_OPT_LIT0 = 4'hA;

  // add/copy option: bit 3 selects copy, bits 2..0 the target
  localparam int unsigned ADDCOPY_SEL_BIT = 3;

  // =====================================================================
  // targets (index into the limit bank)
  localparam logic [2:0] TGT_TLIM0 = 3'h0;
  localparam logic [2:0] TGT_TLIM1 = 3'h1;
  localparam logic [2:0] TGT_SDLIM = 3'h2;
  localparam logic [2:0] TGT_C0LIM = 3'h3;
  localparam logic [2:0] TGT_C1LIM = 3'h4;
  localparam logic [2:0] TGT_LIT0  = 3'h5;

  typedef enum logic [1:0] {
    ST_IDLE,
    ST_FETCH,
    ST_EXEC,
    ST_WAIT
  } ptss_state_e;

  // five-bit operand formed from opcode bit 0 above the option nibble
  function automatic logic [QPTR_W-1:0] step_operand(input logic [STEP_W-1:0] s);
    return {s[4], s[3:0]};
  endfunction

endpackage

// ---- hw/ptss_step_mem.sv ----
// step queue storage: one write port from software, a registered read
// port for the sequencer and a plain read port for register read-back.
// assumes the caller registers the read-back data.
`timescale 1ns/100ps

module ptss_step_mem #(
  parameter int unsigned DEPTH = 8,
  parameter int unsigned WIDTH = 8
) (
  input  wire logic                     mclk_i,
  input  wire logic                     sys_rst_i,
  input  wire logic                     wr_en_i,
  input  wire logic [$clog2(DEPTH)-1:0] wr_idx_i,
  input  wire logic [WIDTH-1:0]         wr_data_i,
  input  wire logic [$clog2(DEPTH)-1:0] seq_idx_i,
  output logic      [WIDTH-1:0]         seq_data_o,
  input  wire logic [$clog2(DEPTH)-1:0] bus_idx_i,
  output logic      [WIDTH-1:0]         bus_data_o
);

  initial begin
    if (DEPTH < 2 || (DEPTH & (DEPTH - 1)) != 0) begin
      $error("queue depth must be a power of two");
    end
  end

  logic [WIDTH-1:0] mem_reg [DEPTH];
  logic [WIDTH-1:0] seq_data_reg;

  always_ff @(posedge mclk_i) begin
    if (sys_rst_i) begin
      for (int i = 0; i < DEPTH; i++) begin
        mem_reg[i] <= '0;
      end
      seq_data_reg <= '0;
    end else begin
      if (wr_en_i) begin
        mem_reg[wr_idx_i] <= wr_data_i;
      end
      seq_data_reg <= mem_reg[seq_idx_i];
    end
  end

  assign seq_data_o = seq_data_reg;
  assign bus_data_o = mem_reg[bus_idx_i];

endmodule

// ---- hw/ptss_edge_det.sv ----
// edge detector for the trigger inputs; inputs are synchronous to mclk_i.
`timescale 1ns/100ps

module ptss_edge_det #(
  parameter int unsigned WIDTH = 16
) (
  input  wire logic             mclk_i,
  input  wire logic             sys_rst_i,
  input  wire logic [WIDTH-1:0] level_i,
  output logic      [WIDTH-1:0] rise_o,
  output logic      [WIDTH-1:0] fall_o
);

  logic [WIDTH-1:0] prev_reg;

  always_ff @(posedge mclk_i) begin
    if (sys_rst_i) begin
      prev_reg <= '0;
    end else begin
      prev_reg <= level_i;
    end
  end

  assign rise_o = level_i & ~prev_reg;
  assign fall_o = ~level_i & prev_reg;

endmodule

// ---- hw/ptss_top.sv ----
// step command decoder and executor with its register file.
// assumes a plain register port (one-cycle strobes, read data next cycle)
// and trigger inputs synchronous to mclk_i.
`timescale 1ns/100ps

module ptss_top
  import ptss_pkg::*;
#(
  parameter int unsigned QUEUE_DEPTH_P = ptss_pkg::QUEUE_DEPTH
) (
  input  wire logic                             mclk_i,
  input  wire logic                             sys_rst_i,
  input  wire logic [ptss_pkg::ADDR_W-1:0]      reg_addr_i,
  input  wire logic [ptss_pkg::DATA_W-1:0]      reg_wdata_i,
  input  wire logic                             reg_wr_i,
  input  wire logic                             reg_rd_i,
  output logic      [ptss_pkg::DATA_W-1:0]      reg_rdata_o,
  input  wire logic [ptss_pkg::TRIG_IN_W-1:0]   trig_in_i,
  output logic      [ptss_pkg::TRIG_OUT_W-1:0]  trig_out_o,
  output logic      [ptss_pkg::DATA_W-1:0]      adc_channel0_select_o,
  output logic                                  adc_select_wr_o,
  output logic                                  irq_o
);
  import ptss_pkg::*;

  localparam int unsigned QIDX_W = $clog2(QUEUE_DEPTH_P);

  initial begin
    if (QUEUE_DEPTH_P < 2 || QUEUE_DEPTH_P >= (1 << ADDR_W) - int'(OFF_QUE_BASE)) begin
      $error("queue depth outside the register window");
    end
  end

  // =====================================================================
  // state
  ptss_state_e                state_reg;
  logic [QPTR_W-1:0]          qptr_reg;
  logic                       en_reg;
  logic                       start_reg;
  logic [DATA_W-1:0]          adj_reg;
  logic [DATA_W-1:0]          hold_reg;
  logic [DATA_W-1:0]          lim_reg [NUM_LIM];
  logic [DATA_W-1:0]          cnt0_reg;
  logic [DATA_W-1:0]          cnt1_reg;
  logic [DATA_W-1:0]          adcsel_reg;
  logic                       adcsel_wr_reg;
  logic [TRIG_OUT_W-1:0]      trig_reg;
  logic [IRQ_W-1:0]           irq_stat_reg;
  logic [IRQ_W-1:0]           irq_mask_reg;
  logic                       irq_reg;
  logic [DATA_W-1:0]          rdata_reg;

  // =====================================================================
  // step queue and trigger edges
  logic [STEP_W-1:0]          step;
  logic [STEP_W-1:0]          bus_step;
  logic [TRIG_IN_W-1:0]       rise;
  logic [TRIG_IN_W-1:0]       fall;

  wire running    = en_reg && start_reg;
  wire sw_wr_open = reg_wr_i && !running;
  wire is_queue   = reg_addr_i >= OFF_QUE_BASE
                 && reg_addr_i < OFF_QUE_BASE + ADDR_W'(QUEUE_DEPTH_P);
  wire queue_wr   = sw_wr_open && is_queue;

  ptss_step_mem #(
    .DEPTH (QUEUE_DEPTH_P),
    .WIDTH (STEP_W)
  ) u_mem (
    .mclk_i     (mclk_i),
    .sys_rst_i  (sys_rst_i),
    .wr_en_i    (queue_wr),
    .wr_idx_i   (reg_addr_i[QIDX_W-1:0]),
    .wr_data_i  (reg_wdata_i[STEP_W-1:0]),
    .seq_idx_i  (qptr_reg[QIDX_W-1:0]),
    .seq_data_o (step),
    .bus_idx_i  (reg_addr_i[QIDX_W-1:0]),
    .bus_data_o (bus_step)
  );

  ptss_edge_det #(
    .WIDTH (TRIG_IN_W)
  ) u_edge (
    .mclk_i    (mclk_i),
    .sys_rst_i (sys_rst_i),
    .level_i   (trig_in_i),
    .rise_o    (rise),
    .fall_o    (fall)
  );

  // =====================================================================
  // register decode
  wire wr_ctrl    = reg_wr_i && reg_addr_i == OFF_CTRL;
  wire wr_adj     = sw_wr_open && reg_addr_i == OFF_ADJ;
  wire wr_hold    = sw_wr_open && reg_addr_i == OFF_HOLD;
  wire wr_istat   = reg_wr_i && reg_addr_i == OFF_IRQ_STAT;
  wire wr_imask   = reg_wr_i && reg_addr_i == OFF_IRQ_MASK;
  wire is_lim     = reg_addr_i >= OFF_LIM_BASE
                 && reg_addr_i < OFF_LIM_BASE + ADDR_W'(NUM_LIM);
  wire wr_lim     = sw_wr_open && is_lim;
  wire [2:0] sw_lim_idx = 3'(reg_addr_i - OFF_LIM_BASE);

  logic [DATA_W-1:0] rd_mux;
  always_comb begin
    rd_mux = RST_WORD;
    if (is_lim) begin
      rd_mux = lim_reg[sw_lim_idx];
    end else if (is_queue) begin
      rd_mux = {{(DATA_W-STEP_W){1'b0}}, bus_step};
    end else begin
      unique case (reg_addr_i)
        OFF_CTRL: begin
          rd_mux[CTRL_EN_BIT]    = en_reg;
          rd_mux[CTRL_START_BIT] = start_reg;
        end
        OFF_STAT: begin
          rd_mux[QPTR_W-1:0]    = qptr_reg;
          rd_mux[STAT_WAIT_BIT] = state_reg == ST_WAIT;
          rd_mux[STAT_BUSY_BIT] = state_reg != ST_IDLE;
        end
        OFF_ADJ:      rd_mux = adj_reg;
        OFF_HOLD:     rd_mux = hold_reg;
        OFF_CNT0:     rd_mux = cnt0_reg;
        OFF_CNT1:     rd_mux = cnt1_reg;
        OFF_ADCSEL:   rd_mux = adcsel_reg;
        OFF_IRQ_STAT: rd_mux = irq_stat_reg;
        OFF_IRQ_MASK: rd_mux = irq_mask_reg;
        default:      rd_mux = RST_WORD;
      endcase
    end
  end

  // =====================================================================
  // step decode
  wire [3:0]        opcode  = step[7:4];
  wire [3:0]        option  = step[3:0];
  wire [2:0]        op_grp  = opcode[3:1];
  wire [QPTR_W-1:0] operand = step_operand(step);
  wire [QPTR_W-1:0] qptr_inc = qptr_reg + QPTR_W'(1);
  wire              exec    = state_reg == ST_EXEC;
  wire              is_copy = option[ADDCOPY_SEL_BIT];
  wire [2:0]        tgt     = option[2:0];
  wire              tgt_ok  = tgt <= TGT_LIT0;
  wire              addcopy = exec && op_grp == GRP_CTRL_ADD && opcode[0] && tgt_ok;
  wire [DATA_W-1:0] tgt_val = is_copy ? hold_reg
                                      : lim_reg[tgt] + adj_reg;
  wire              lit_ld  = exec && op_grp == GRP_CTRL_ADD && !opcode[0]
                           && option == CTRL_OPT_LIT0;
  wire              strobe  = exec && op_grp == GRP_STROBE;
  wire              c0_done = cnt0_reg == lim_reg[TGT_C0LIM];
  wire              c1_done = cnt1_reg == lim_reg[TGT_C1LIM];
  wire              wait_hit = opcode[0] ? fall[option] : rise[option];

  // =====================================================================
  // sequencer
  always_ff @(posedge mclk_i) begin
    if (sys_rst_i) begin
      state_reg <= ST_IDLE;
      qptr_reg  <= RST_QPTR;
      cnt0_reg  <= RST_WORD;
      cnt1_reg  <= RST_WORD;
    end else if (!running) begin
      state_reg <= ST_IDLE;
    end else begin
      unique case (state_reg)
        ST_IDLE: begin
          qptr_reg  <= RST_QPTR;
          cnt0_reg  <= RST_WORD;
          cnt1_reg  <= RST_WORD;
          state_reg <= ST_FETCH;
        end
        ST_FETCH: begin
          state_reg <= ST_EXEC;
        end
        ST_EXEC: begin
          state_reg <= ST_FETCH;
          unique case (op_grp)
            GRP_WAIT: begin
              if (!opcode[0] || opcode[0]) begin
                state_reg <= ST_WAIT;
              end
            end
            GRP_JUMP: qptr_reg <= operand;
            GRP_JMPC0: begin
              if (c0_done) begin
                qptr_reg <= qptr_inc;
              end else begin
                cnt0_reg <= cnt0_reg + DATA_W'(1);
                qptr_reg <= operand;
              end
            end
            GRP_JMPC1: begin
              if (c1_done) begin
                qptr_reg <= qptr_inc;
              end else begin
                cnt1_reg <= cnt1_reg + DATA_W'(1);
                qptr_reg <= operand;
              end
            end
            default: qptr_reg <= qptr_inc;
          endcase
        end
        ST_WAIT: begin
          if (wait_hit) begin
            qptr_reg  <= qptr_inc;
            state_reg <= ST_FETCH;
          end
        end
      endcase
    end
  end

  // =====================================================================
  // software registers and step targets
  always_ff @(posedge mclk_i) begin
    if (sys_rst_i) begin
      en_reg    <= 1'b0;
      start_reg <= 1'b0;
      adj_reg   <= RST_WORD;
      hold_reg  <= RST_WORD;
      for (int i = 0; i < NUM_LIM; i++) begin
        lim_reg[i] <= RST_WORD;
      end
    end else begin
      if (wr_ctrl) begin
        en_reg    <= reg_wdata_i[CTRL_EN_BIT];
        start_reg <= reg_wdata_i[CTRL_START_BIT];
      end
      if (wr_adj) begin
        adj_reg <= reg_wdata_i;
      end
      if (wr_hold) begin
        hold_reg <= reg_wdata_i;
      end
      for (int i = 0; i < NUM_LIM; i++) begin
        if (addcopy && tgt == 3'(i)) begin
          lim_reg[i] <= tgt_val;
        end else if (wr_lim && sw_lim_idx == 3'(i)) begin
          lim_reg[i] <= reg_wdata_i;
        end
      end
    end
  end

  // =====================================================================
  // peripheral side outputs
  always_ff @(posedge mclk_i) begin
    if (sys_rst_i) begin
      adcsel_reg    <= RST_WORD;
      adcsel_wr_reg <= 1'b0;
      trig_reg      <= '0;
    end else begin
      adcsel_wr_reg <= lit_ld || strobe;
      trig_reg      <= '0;
      if (lit_ld) begin
        adcsel_reg <= lim_reg[TGT_LIT0];
      end else if (strobe) begin
        adcsel_reg[ADCSEL_FIELD_W-1:0] <= operand;
      end
      if (exec && op_grp == GRP_TRIG) begin
        trig_reg[operand] <= 1'b1;
      end
    end
  end

  // =====================================================================
  // interrupts: sticky status, write one to clear, set wins
  wire [IRQ_W-1:0] irq_set = (exec && op_grp == GRP_IRQ && opcode[0])
                           ? IRQ_W'(1) << option : '0;
  wire [IRQ_W-1:0] irq_clr = wr_istat ? reg_wdata_i : '0;
  wire [IRQ_W-1:0] irq_stat_next = (irq_stat_reg & ~irq_clr) | irq_set;

  always_ff @(posedge mclk_i) begin
    if (sys_rst_i) begin
      irq_stat_reg <= '0;
      irq_mask_reg <= '0;
      irq_reg      <= 1'b0;
      rdata_reg    <= RST_WORD;
    end else begin
      irq_stat_reg <= irq_stat_next;
      if (wr_imask) begin
        irq_mask_reg <= reg_wdata_i;
      end
      irq_reg   <= |(irq_stat_next & (wr_imask ? reg_wdata_i : irq_mask_reg));
      rdata_reg <= reg_rd_i ? rd_mux : RST_WORD;
    end
  end

  assign reg_rdata_o           = rdata_reg;
  assign trig_out_o            = trig_reg;
  assign adc_channel0_select_o = adcsel_reg;
  assign adc_select_wr_o       = adcsel_wr_reg;
  assign irq_o                 = irq_reg;

endmodule

// ---- verif/ptss_properties.sv ----
// port checker for the step sequencer top, bound into every instance.
// assumes one clock domain and a synchronous active-high reset.
`timescale 1ns/100ps

module ptss_properties
  import ptss_pkg::*;
#(
  parameter int unsigned QUEUE_DEPTH_P = 8
) (
  input wire logic                            mclk_i,
  input wire logic                            sys_rst_i,
  input wire logic [ptss_pkg::ADDR_W-1:0]     reg_addr_i,
  input wire logic [ptss_pkg::DATA_W-1:0]     reg_wdata_i,
  input wire logic                            reg_wr_i,
  input wire logic                            reg_rd_i,
  input wire logic [ptss_pkg::DATA_W-1:0]     reg_rdata_o,
  input wire logic [ptss_pkg::TRIG_IN_W-1:0]  trig_in_i,
  input wire logic [ptss_pkg::TRIG_OUT_W-1:0] trig_out_o,
  input wire logic [ptss_pkg::DATA_W-1:0]     adc_channel0_select_o,
  input wire logic                            adc_select_wr_o,
  input wire logic                            irq_o
);
  logic              run_reg;
  logic [DATA_W-1:0] mask_reg;
  wire               ctrl_wr;
  wire               mask_wr;

  assign ctrl_wr = reg_wr_i && (reg_addr_i == OFF_CTRL);
  assign mask_wr = reg_wr_i && (reg_addr_i == OFF_IRQ_MASK);

  default clocking cb @(posedge mclk_i); endclocking
  default disable iff (sys_rst_i);

  // ===================================================================
  // shadows of the running state and the interrupt mask
  always_ff @(posedge mclk_i) begin
    if (sys_rst_i) begin
      run_reg  <= 1'b0;
      mask_reg <= '0;
    end else begin
      if (ctrl_wr) begin
        run_reg <= (reg_wdata_i[1:0] == 2'b11);
      end
      if (mask_wr) begin
        mask_reg <= reg_wdata_i;
      end
    end
  end

  // ===================================================================
  // assertions
  a_rdata_idle_zero: assert property (!reg_rd_i |=> reg_rdata_o == 16'h0000)
    else $error("read data not zero outside the read slot");
  a_trig_one_hot: assert property (trig_out_o != '0 |-> $onehot(trig_out_o))
    else $error("more than one trigger output raised");
  a_trig_single_pulse: assert property (trig_out_o != '0 |=> trig_out_o == '0)
    else $error("trigger output longer than one cycle");
  a_adc_wr_pulse: assert property (adc_select_wr_o |=> !adc_select_wr_o)
    else $error("adc select write strobe too long");
  a_adc_level_held: assert property ($changed(adc_channel0_select_o) |-> adc_select_wr_o)
    else $error("adc select changed without a step write");
  a_irq_mask_gate: assert property (mask_reg == '0 && $past(mask_reg) == '0 |-> !irq_o)
    else $error("interrupt raised while fully masked");
  a_trig_needs_run: assert property (trig_out_o != '0 |-> run_reg || $past(run_reg))
    else $error("trigger output while sequencer stopped");
  a_adc_needs_run: assert property (adc_select_wr_o |-> run_reg || $past(run_reg))
    else $error("adc select written while sequencer stopped");
  a_queue_byte_wide: assert property (
    $past(reg_rd_i) && $past(reg_addr_i[4:3]) == 2'b10 |-> reg_rdata_o[15:8] == 8'h00)
    else $error("queue entry upper byte not zero");

  c_trig_pulse: cover property (trig_out_o != '0);
  c_irq_raised: cover property ($rose(irq_o));
  c_adc_written: cover property (adc_select_wr_o);
endmodule

bind ptss_top ptss_properties #(.QUEUE_DEPTH_P(QUEUE_DEPTH_P)) chk_u (
  .mclk_i(mclk_i), .sys_rst_i(sys_rst_i), .reg_addr_i(reg_addr_i),
  .reg_wdata_i(reg_wdata_i), .reg_wr_i(reg_wr_i), .reg_rd_i(reg_rd_i),
  .reg_rdata_o(reg_rdata_o), .trig_in_i(trig_in_i), .trig_out_o(trig_out_o),
  .adc_channel0_select_o(adc_channel0_select_o),
  .adc_select_wr_o(adc_select_wr_o), .irq_o(irq_o)
);

// ---- verif/ptss_periph_model.sv ----
// on-chip peripheral stand-in: drives trigger levels, records trigger
// pulses and adc select writes; assumes everything runs on mclk_i.
`timescale 1ns/100ps

module ptss_periph_model (
  input  wire logic        mclk_i,
  input  wire logic        sys_rst_i,
  input  wire logic [15:0] lvl_i,
  input  wire logic [31:0] trig_i,
  input  wire logic        adc_wr_i,
  input  wire logic [15:0] adc_sel_i,
  output logic      [15:0] trig_in_o,
  output logic      [7:0]  trig_cnt_o,
  output logic      [31:0] trig_seen_o,
  output logic      [7:0]  adc_cnt_o,
  output logic      [15:0] adc_seen_o
);
  // ===================================================================
  // levels change only on the clock, like a synchronous on-chip source
  always_ff @(posedge mclk_i) begin
    if (sys_rst_i) begin
      trig_in_o   <= 16'h0000;
      trig_cnt_o  <= 8'h00;
      trig_seen_o <= 32'h0000_0000;
      adc_cnt_o   <= 8'h00;
      adc_seen_o  <= 16'h0000;
    end else begin
      trig_in_o <= lvl_i;
      if (trig_i != 32'h0000_0000) begin
        trig_cnt_o  <= trig_cnt_o + 8'h01;
        trig_seen_o <= trig_seen_o | trig_i;
      end
      if (adc_wr_i) begin
        adc_cnt_o  <= adc_cnt_o + 8'h01;
        adc_seen_o <= adc_sel_i;
      end
    end
  end
endmodule

// ---- verif/tb_top.sv ----
// self-checking bench for the step sequencer: register port tasks and
// two step programs; assumes the peripheral model in ptss_periph_model.
`timescale 1ns/100ps

module tb_top;
  import ptss_pkg::*;
  localparam logic [7:0] PROG_A [8] = '{8'h12, 8'h1D, 8'h0A, 8'h3C,
                                        8'h95, 8'hC4, 8'h63, 8'hA7};
  localparam logic [7:0] PROG_B [8] = '{8'h42, 8'h51, 8'h75, 8'hE3,
                                        8'h0B, 8'hA5, 8'h00, 8'h00};
  logic              mclk;
  logic              rst;
  logic [ADDR_W-1:0] ra;
  logic [DATA_W-1:0] wd;
  logic              wr;
  logic              rd;
  logic [DATA_W-1:0] rdat;
  logic [15:0]       tin;
  logic [31:0]       tout;
  logic [15:0]       adc;
  logic              adc_wr;
  logic              irq;
  logic              irq_s;
  logic [15:0]       lvl;
  logic [7:0]        tcnt;
  logic [31:0]       tseen;
  logic [7:0]        acnt;
  logic [15:0]       aseen;
  logic [15:0]       v;
  int                fails;
  int                compares;

  ptss_top dut_u (
    .mclk_i(mclk), .sys_rst_i(rst), .reg_addr_i(ra), .reg_wdata_i(wd),
    .reg_wr_i(wr), .reg_rd_i(rd), .reg_rdata_o(rdat), .trig_in_i(tin),
    .trig_out_o(tout), .adc_channel0_select_o(adc),
    .adc_select_wr_o(adc_wr), .irq_o(irq)
  );

  ptss_periph_model pm_u (
    .mclk_i(mclk), .sys_rst_i(rst), .lvl_i(lvl), .trig_i(tout),
    .adc_wr_i(adc_wr), .adc_sel_i(adc), .trig_in_o(tin),
    .trig_cnt_o(tcnt), .trig_seen_o(tseen), .adc_cnt_o(acnt),
    .adc_seen_o(aseen)
  );

  // ===================================================================
  // helpers
  task automatic finish_test();
    $display("compares %0d fails %0d", compares, fails);
    if (fails == 0 && compares > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask

  task automatic chk(input string n, input logic [31:0] s, input logic [31:0] e);
    compares++;
    if (s !== e) begin
      fails++;
      $display("ERROR %s expected %h seen %h", n, e, s);
    end
  endtask

  task automatic wr_reg(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d);
    ra <= a;
    wd <= d;
    wr <= 1'b1;
    @(posedge mclk);
    wr <= 1'b0;
    @(posedge mclk);
  endtask

  // read data and irq are sampled settled, inside the answer cycle
  task automatic rd_chk(input logic [ADDR_W-1:0] a, input logic [15:0] e,
                        input string n);
    ra <= a;
    rd <= 1'b1;
    @(posedge mclk);
    rd <= 1'b0;
    #1;
    v = rdat;
    irq_s = irq;
    chk(n, v, e);
    @(posedge mclk);
  endtask

  task automatic load(input logic [7:0] p [8]);
    for (int i = 0; i < 8; i++) begin
      wr_reg(OFF_QUE_BASE + 5'(i), {8'h00, p[i]});
    end
  endtask

  task automatic wait_until(input bit on_irq);
    int i;
    for (i = 0; i < 300; i++) begin
      if (on_irq ? irq === 1'b1 : tcnt === 8'h03) break;
      @(posedge mclk);
    end
    if (i == 300) begin
      fails++;
      $display("ERROR wait expected event seen none");
      finish_test();
    end
  endtask

  // ===================================================================
  // clock and main sequence
  initial begin
    mclk = 1'b0;
    forever #2.5 mclk = ~mclk;
  end

  initial begin
    rst = 1'b1;
    ra = '0;
    wd = '0;
    wr = 1'b0;
    rd = 1'b0;
    lvl = 16'h0000;
    fails = 0;
    compares = 0;
    repeat (10) @(posedge mclk);
    rst <= 1'b0;
    lvl <= 16'h0002;
    @(posedge mclk);
    rd_chk(OFF_ADJ, 16'h0000, "adjust reset");
    rd_chk(5'h09, 16'h0000, "literal reset");
    wr_reg(OFF_ADJ, 16'h0003);
    wr_reg(OFF_HOLD, 16'h0040);
    wr_reg(5'h06, 16'h0010);
    wr_reg(5'h07, 16'h0002);
    wr_reg(5'h09, 16'h00AB);
    rd_chk(5'h09, 16'h00AB, "literal rw");
    rd_chk(5'h0F, 16'h0000, "unmapped");
    load(PROG_A);
    rd_chk(OFF_QUE_BASE + 5'h03, 16'h003C, "queue entry");
    $display("test registers done");
    wr_reg(OFF_CTRL, 16'h0003);
    wait_until(1'b0);
    wr_reg(OFF_ADJ, 16'hFFFF);
    wr_reg(5'h09, 16'h1111);
    rd_chk(OFF_ADJ, 16'h0003, "adjust locked");
    rd_chk(5'h09, 16'h0040, "literal copied");
    rd_chk(5'h06, 16'h0013, "delay limit sum");
    rd_chk(OFF_CNT0, 16'h0002, "loop counter zero");
    rd_chk(OFF_ADCSEL, 16'h005C, "adc select");
    rd_chk(OFF_STAT, 16'h0207, "pointer park");
    chk("queue pointer", v[4:0], 5'h07);
    chk("trigger seen", tseen, 32'h0020_0000);
    chk("trigger count", tcnt, 8'h03);
    chk("adc writes", acnt, 8'h02);
    chk("adc seen", aseen, 16'h005C);
    wr_reg(OFF_CTRL, 16'h0000);
    wr_reg(OFF_ADJ, 16'h0007);
    rd_chk(OFF_ADJ, 16'h0007, "adjust unlocked");
    $display("test program a done");
    load(PROG_B);
    wr_reg(OFF_IRQ_MASK, 16'h0020);
    wr_reg(5'h08, 16'h0001);
    wr_reg(OFF_CTRL, 16'h0003);
    repeat (10) @(posedge mclk);
    rd_chk(OFF_IRQ_STAT, 16'h0000, "irq before edge");
    rd_chk(OFF_STAT, 16'h0300, "stall on rise");
    chk("wait flag", v[8], 1'b1);
    lvl <= 16'h0006;
    repeat (10) @(posedge mclk);
    rd_chk(OFF_IRQ_STAT, 16'h0000, "irq before fall");
    lvl <= 16'h0004;
    wait_until(1'b1);
    rd_chk(OFF_IRQ_STAT, 16'h0020, "irq status");
    chk("irq raised", irq_s, 1'b1);
    repeat (10) @(posedge mclk);
    rd_chk(OFF_CNT1, 16'h0001, "loop counter one");
    rd_chk(OFF_STAT, 16'h0205, "pointer after c1");
    chk("adc writes kept", acnt, 8'h02);
    wr_reg(OFF_IRQ_MASK, 16'h0000);
    rd_chk(OFF_IRQ_STAT, 16'h0020, "status masked");
    chk("irq masked", irq_s, 1'b0);
    wr_reg(OFF_IRQ_MASK, 16'h0020);
    wr_reg(OFF_IRQ_STAT, 16'h0020);
    rd_chk(OFF_IRQ_STAT, 16'h0000, "status cleared");
    chk("irq cleared", irq_s, 1'b0);
    wr_reg(OFF_CTRL, 16'h0000);
    $display("test program b done");
    finish_test();
  end
endmodule
